// [pkg/afecfg_pkg.sv]
// constants and types for the front end configuration word block
// assumes a single 200 MHz clock and a plain word-wide register port
package afecfg_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int TEMP_W = 16;
    // register byte addresses
    localparam logic [31:0] FRONTEND_CONFIG_ADDR = 32'h0000_2000;
    localparam logic [31:0] TEMP_RESULT_ADDR = 32'h0000_2004;
    localparam logic [31:0] FRONTEND_CONFIG_RESET = 32'h0008_0000;
    // writable bits of the configuration word, upper bits kept as plain storage
    localparam logic [31:0] FRONTEND_CONFIG_RW_MASK = 32'h0039_FFE0;
    // field positions
    localparam int WAVEGEN_ON_BIT = 14;
    localparam int TEMP_TRIGGER_BIT = 13;
    localparam int TEMP_POWER_BIT = 12;
    localparam int HS_TIA_BIT = 11;
    localparam int INSTR_AMP_BIT = 10;
    localparam int EXC_BUF_BIT = 9;
    localparam int CONV_RUN_BIT = 8;
    localparam int CONV_POWER_BIT = 7;
    localparam int HS_DAC_BIT = 6;
    localparam int HP_REF_PD_BIT = 5;
    // temperature conversion time
    localparam int TEMP_CONV_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TEMP_CONV_CYCLES = (TEMP_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // temperature conversion states
    typedef enum logic [2:0] {
        AFECFG_T_IDLE = 3'b001,
        AFECFG_T_CONV = 3'b010,
        AFECFG_T_DONE = 3'b100
    } afecfg_tstate_e;
endpackage

// [pkg/afecfg_tmp_if.sv]
// handshake between the register bank and the temperature conversion unit
// assumes both ends share one clock
`timescale 1ns/1ps
interface afecfg_tmp_if;
    logic start;
    logic enable;
    logic done;
    logic [afecfg_pkg::TEMP_W-1:0] result;
    modport ctrl (output start, output enable, input done, input result);
    modport conv (input start, input enable, output done, output result);
endinterface

// [hdl/afecfg_tempconv.sv]
// temperature conversion sequencer: counts the conversion time then latches a sample
// assumes the sensor sample input is already synchronised upstream
`timescale 1ns/1ps
module afecfg_tempconv #(
    parameter int CONV_CYCLES = afecfg_pkg::TEMP_CONV_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control side
    afecfg_tmp_if.conv tif,
    // sensor sample
    input wire logic [afecfg_pkg::TEMP_W-1:0] sensor_sample
);
    afecfg_pkg::afecfg_tstate_e state_q;
    logic [15:0] cnt_q;

    // sequence: start only with the sensor powered, wait, capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= afecfg_pkg::AFECFG_T_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                afecfg_pkg::AFECFG_T_IDLE: begin
                    cnt_q <= 16'h0000;
                    if (tif.start && tif.enable) begin
                        state_q <= afecfg_pkg::AFECFG_T_CONV;
                    end
                end
                afecfg_pkg::AFECFG_T_CONV: begin
                    if (!tif.enable) begin
                        state_q <= afecfg_pkg::AFECFG_T_IDLE; // enable dropped: sensor power or trigger cleared
                    end else if (cnt_q == 16'(CONV_CYCLES - 1)) begin
                        state_q <= afecfg_pkg::AFECFG_T_DONE;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                afecfg_pkg::AFECFG_T_DONE: begin
                    cnt_q <= 16'h0000;
                    // a trigger landing on the done cycle is not lost
                    if (tif.start && tif.enable) begin
                        state_q <= afecfg_pkg::AFECFG_T_CONV;
                    end else begin
                        state_q <= afecfg_pkg::AFECFG_T_IDLE;
                    end
                end
                default: state_q <= afecfg_pkg::AFECFG_T_IDLE;
            endcase
        end
    end

    // result capture at the end of a conversion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tif.result <= '0;
        end else if (state_q == afecfg_pkg::AFECFG_T_CONV && tif.enable
                     && cnt_q == 16'(CONV_CYCLES - 1)) begin
            tif.result <= sensor_sample;
        end
    end

    assign tif.done = (state_q == afecfg_pkg::AFECFG_T_DONE);
endmodule

// [hdl/afecfg_sync.sv]
// two-flop synchroniser for a bus of pin-level inputs
// assumes inputs are quasi-static relative to clk
`timescale 1ns/1ps
module afecfg_sync #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// [hdl/afecfg_top.sv]
// front end configuration word: block enables, temperature trigger and result
// assumes a register port with one-cycle strobes and read data the next cycle
//
// What this block does
// - bit 14 turns the waveform generator on or off, reset off.
// - writing 1 to bit 13 with bit 12 also set starts a temperature conversion.
// - a finished temperature conversion leaves its result readable by software.
// - bit 12 powers the temperature sensor up or down, reset down.
// - no temperature reading happens unless trigger bit is also set.
// - bit 11 enables the high speed transimpedance amplifier.
// - bit 10 enables the excitation instrumentation amplifier.
// - bit 9 enables the excitation buffer.
// - bit 8 enables conversions; when clear a powered converter idles.
// - bit 7 powers the converter; software also sets the run bit.
// - bit 6 enables the output converter path, not the waveform generator.
// - bit 5 high powers the reference down; reset keeps it on.
// - the word is 32-bit read/write at 0x2000, reset 0x00080000.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module afecfg_top #(
    parameter int CONV_CYCLES = afecfg_pkg::TEMP_CONV_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [afecfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [afecfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [afecfg_pkg::DATA_W-1:0] reg_rdata,
    // temperature sensor sample pins
    input wire logic [afecfg_pkg::TEMP_W-1:0] temp_sensor_pins,
    // analog enables
    output logic wavegen_on,
    output logic temp_sensor_power,
    output logic temp_convert_trigger,
    output logic hs_transimpedance_on,
    output logic instr_amp_on,
    output logic excitation_buffer_on,
    output logic conversion_run,
    output logic converter_power,
    output logic hs_output_converter_power,
    output logic hp_reference_powerdown,
    // converter actually converting
    output logic converter_active,
    // temperature conversion busy
    output logic temp_busy
);
    logic cfg_wr;
    logic [31:0] cfg_word;
    logic [31:0] spare_q;
    logic [31:0] rdata_d;
    logic wavegen_q;
    logic temp_trigger_q;
    logic temp_power_q;
    logic hs_tz_amp_q;
    logic instr_amp_q;
    logic exc_buf_q;
    logic conv_run_q;
    logic conv_power_q;
    logic out_conv_q;
    logic hp_ref_pd_q;
    logic [afecfg_pkg::TEMP_W-1:0] temp_result;
    logic [afecfg_pkg::TEMP_W-1:0] sample_sync;
    logic start_pulse;
    logic busy_q;
    afecfg_tmp_if tif ();

    // address match helper
    function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
        hit = (a == base);
    endfunction

    // positions of the ten enable fields in the word
    function automatic logic [31:0] enable_mask();
        logic [31:0] m;
        m = afecfg_pkg::ZERO_WORD;
        m[afecfg_pkg::WAVEGEN_ON_BIT] = 1'b1;
        m[afecfg_pkg::TEMP_TRIGGER_BIT] = 1'b1;
        m[afecfg_pkg::TEMP_POWER_BIT] = 1'b1;
        m[afecfg_pkg::HS_TIA_BIT] = 1'b1;
        m[afecfg_pkg::INSTR_AMP_BIT] = 1'b1;
        m[afecfg_pkg::EXC_BUF_BIT] = 1'b1;
        m[afecfg_pkg::CONV_RUN_BIT] = 1'b1;
        m[afecfg_pkg::CONV_POWER_BIT] = 1'b1;
        m[afecfg_pkg::HS_DAC_BIT] = 1'b1;
        m[afecfg_pkg::HP_REF_PD_BIT] = 1'b1;
        return m;
    endfunction

    // write to the configuration word in this cycle
    assign cfg_wr = reg_write && hit(reg_addr, afecfg_pkg::FRONTEND_CONFIG_ADDR);

    // spare storage: writable bits that drive no enable; reserved bits stay zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spare_q <= afecfg_pkg::FRONTEND_CONFIG_RESET;
        end else if (cfg_wr) begin
            spare_q <= reg_wdata & afecfg_pkg::FRONTEND_CONFIG_RW_MASK & ~enable_mask();
        end
    end

    // waveform generator enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wavegen_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::WAVEGEN_ON_BIT];
        end else if (cfg_wr) begin
            wavegen_q <= reg_wdata[afecfg_pkg::WAVEGEN_ON_BIT];
        end
    end

    // temperature conversion trigger
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            temp_trigger_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::TEMP_TRIGGER_BIT];
        end else if (cfg_wr) begin
            temp_trigger_q <= reg_wdata[afecfg_pkg::TEMP_TRIGGER_BIT];
        end
    end

    // temperature sensor power
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            temp_power_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::TEMP_POWER_BIT];
        end else if (cfg_wr) begin
            temp_power_q <= reg_wdata[afecfg_pkg::TEMP_POWER_BIT];
        end
    end

    // high speed transimpedance amplifier enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_tz_amp_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::HS_TIA_BIT];
        end else if (cfg_wr) begin
            hs_tz_amp_q <= reg_wdata[afecfg_pkg::HS_TIA_BIT];
        end
    end

    // excitation instrumentation amplifier enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_amp_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::INSTR_AMP_BIT];
        end else if (cfg_wr) begin
            instr_amp_q <= reg_wdata[afecfg_pkg::INSTR_AMP_BIT];
        end
    end

    // excitation buffer enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exc_buf_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::EXC_BUF_BIT];
        end else if (cfg_wr) begin
            exc_buf_q <= reg_wdata[afecfg_pkg::EXC_BUF_BIT];
        end
    end

    // converter run enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_run_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::CONV_RUN_BIT];
        end else if (cfg_wr) begin
            conv_run_q <= reg_wdata[afecfg_pkg::CONV_RUN_BIT];
        end
    end

    // converter power
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_power_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::CONV_POWER_BIT];
        end else if (cfg_wr) begin
            conv_power_q <= reg_wdata[afecfg_pkg::CONV_POWER_BIT];
        end
    end

    // output converter path power, waveform generator untouched
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_conv_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::HS_DAC_BIT];
        end else if (cfg_wr) begin
            out_conv_q <= reg_wdata[afecfg_pkg::HS_DAC_BIT];
        end
    end

    // high power reference power-down, active high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hp_ref_pd_q <= afecfg_pkg::FRONTEND_CONFIG_RESET[afecfg_pkg::HP_REF_PD_BIT];
        end else if (cfg_wr) begin
            hp_ref_pd_q <= reg_wdata[afecfg_pkg::HP_REF_PD_BIT];
        end
    end

    // readable word: spare bits with the enable fields in place
    always_comb begin
        cfg_word = spare_q;
        cfg_word[afecfg_pkg::WAVEGEN_ON_BIT] = wavegen_q;
        cfg_word[afecfg_pkg::TEMP_TRIGGER_BIT] = temp_trigger_q;
        cfg_word[afecfg_pkg::TEMP_POWER_BIT] = temp_power_q;
        cfg_word[afecfg_pkg::HS_TIA_BIT] = hs_tz_amp_q;
        cfg_word[afecfg_pkg::INSTR_AMP_BIT] = instr_amp_q;
        cfg_word[afecfg_pkg::EXC_BUF_BIT] = exc_buf_q;
        cfg_word[afecfg_pkg::CONV_RUN_BIT] = conv_run_q;
        cfg_word[afecfg_pkg::CONV_POWER_BIT] = conv_power_q;
        cfg_word[afecfg_pkg::HS_DAC_BIT] = out_conv_q;
        cfg_word[afecfg_pkg::HP_REF_PD_BIT] = hp_ref_pd_q;
    end

    // a write that sets the trigger bit starts one conversion if bit 12 is also set and none is running
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= reg_write && hit(reg_addr, afecfg_pkg::FRONTEND_CONFIG_ADDR)
                && reg_wdata[afecfg_pkg::TEMP_TRIGGER_BIT];
        end
    end

    // busy flag: set by start, cleared at done or abort; start wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else if (start_pulse && tif.enable) begin
            busy_q <= 1'b1;
        end else if (tif.done || !tif.enable) begin
            busy_q <= 1'b0;
        end
    end

    assign tif.start = start_pulse;
    assign tif.enable = temp_power_q
        && temp_trigger_q;
    assign temp_result = tif.result;

    // pin samples pass two flops
    afecfg_sync #(
        .W(afecfg_pkg::TEMP_W)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din(temp_sensor_pins),
        .dout(sample_sync)
    );

    // temperature conversion sequencer
    afecfg_tempconv #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk(clk),
        .rst_b(rst_b),
        .tif(tif),
        .sensor_sample(sample_sync)
    );

    // read data select: addressed register, zero otherwise
    always_comb begin
        rdata_d = afecfg_pkg::ZERO_WORD; // unmapped reads as zero
        if (reg_read && hit(reg_addr, afecfg_pkg::FRONTEND_CONFIG_ADDR)) begin
            rdata_d = cfg_word;
        end else if (reg_read && hit(reg_addr, afecfg_pkg::TEMP_RESULT_ADDR)) begin
            rdata_d = {16'h0000, temp_result};
        end
    end

    // read data register, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= afecfg_pkg::ZERO_WORD;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // enable outputs straight from the stored word
    assign wavegen_on = wavegen_q;
    assign temp_convert_trigger = temp_trigger_q;
    assign temp_sensor_power = temp_power_q;
    assign hs_transimpedance_on = hs_tz_amp_q;
    assign instr_amp_on = instr_amp_q;
    assign excitation_buffer_on = exc_buf_q;
    assign conversion_run = conv_run_q;
    assign converter_power = conv_power_q;
    assign hs_output_converter_power = out_conv_q;
    assign hp_reference_powerdown = hp_ref_pd_q;

    // converter converts only when powered and running
    assign converter_active = conv_power_q
        && conv_run_q;
    assign temp_busy = busy_q;
endmodule

// [verif/afecfg_top_props.sv]
// checker for the front end configuration word block
// sees only the top module ports; bound to every top instance at the foot
`timescale 1ns/1ps
module afecfg_top_props #(
    parameter int CONV_CYCLES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] temp_sensor_pins,
    // enables and status
    input wire logic wavegen_on,
    input wire logic temp_sensor_power,
    input wire logic temp_convert_trigger,
    input wire logic hs_transimpedance_on,
    input wire logic instr_amp_on,
    input wire logic excitation_buffer_on,
    input wire logic conversion_run,
    input wire logic converter_power,
    input wire logic hs_output_converter_power,
    input wire logic hp_reference_powerdown,
    input wire logic converter_active,
    input wire logic temp_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // write to the configuration word in this cycle
    wire cfg_wr = reg_write && (reg_addr == afecfg_pkg::FRONTEND_CONFIG_ADDR);
    wire [9:0] ens = {wavegen_on, temp_convert_trigger, temp_sensor_power,
        hs_transimpedance_on, instr_amp_on, excitation_buffer_on, conversion_run,
        converter_power, hs_output_converter_power, hp_reference_powerdown};
    a_wavegen_write: assert property (cfg_wr |=> wavegen_on == $past(reg_wdata[14]))
        else $error("waveform enable does not follow write");
    a_temp_bits: assert property (cfg_wr |=> ens[8:7] == $past(reg_wdata[13:12]))
        else $error("temperature bits do not follow write");
    a_amp_bits: assert property (cfg_wr |=> ens[6:4] == $past(reg_wdata[11:9]))
        else $error("amplifier enables do not follow write");
    a_conv_bits: assert property (cfg_wr |=> ens[3:0] == $past(reg_wdata[8:5]))
        else $error("converter or reference bits do not follow write");
    a_enables_hold: assert property (!cfg_wr |=> $stable(ens))
        else $error("enable changed without a write");
    a_active_pair: assert property (converter_active == (converter_power && conversion_run))
        else $error("converter active not power and run");
    a_busy_cause: assert property ($rose(temp_busy) |-> $past(ens[8] && ens[7]))
        else $error("temperature conversion without sensor and trigger");
    a_busy_abort: assert property (temp_busy && !(ens[8] && ens[7]) |=> !temp_busy)
        else $error("temperature conversion kept running after abort");
    a_busy_start: assert property (cfg_wr && reg_wdata[13:12] == 2'b11 && !temp_busy
        |-> ##2 temp_busy)
        else $error("temperature conversion did not start");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_reserved_zero: assert property ($past(reg_read) && $past(reg_addr) == 32'h0000_2000
        |-> reg_rdata[4:0] == 5'h00 && reg_rdata[31:22] == 10'h000
        && reg_rdata[18:17] == 2'b00)
        else $error("reserved bits read nonzero");
    // main scenarios
    c_temp_start: cover property (cfg_wr && reg_wdata[13:12] == 2'b11);
    c_temp_end: cover property ($fell(temp_busy));
    c_conv_active: cover property (converter_active);
endmodule
bind afecfg_top afecfg_top_props #(.CONV_CYCLES(CONV_CYCLES)) i_afecfg_top_props (.clk, .rst_b,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .temp_sensor_pins, .wavegen_on,
    .temp_sensor_power, .temp_convert_trigger, .hs_transimpedance_on, .instr_amp_on,
    .excitation_buffer_on, .conversion_run, .converter_power, .hs_output_converter_power,
    .hp_reference_powerdown, .converter_active, .temp_busy);

// [verif/tb_top.sv]
// self-checking bench for the front end configuration word block
// drives the register port and sensor pins directly, short conversion time
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [31:0] reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, reg_rdata, rd_q;
    logic [15:0] temp_sensor_pins = 16'hA5C3;
    logic [9:0] ens;
    logic converter_active, temp_busy;
    int mismatches = 0, checks = 0;
    afecfg_top #(.CONV_CYCLES(4)) i_afecfg_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .temp_sensor_pins(temp_sensor_pins), .wavegen_on(ens[9]),
        .temp_convert_trigger(ens[8]), .temp_sensor_power(ens[7]),
        .hs_transimpedance_on(ens[6]), .instr_amp_on(ens[5]), .excitation_buffer_on(ens[4]),
        .conversion_run(ens[3]), .converter_power(ens[2]), .hs_output_converter_power(ens[1]),
        .hp_reference_powerdown(ens[0]), .converter_active(converter_active),
        .temp_busy(temp_busy));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 40 && temp_busy !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // reset values of the word and the enables
    task automatic t_reset;
        rd(32'h0000_2000);
        chk("cfg reset", rd_q, 32'h0008_0000);
        chk("enables reset", {22'h0, ens}, 32'h0000_0000);
    endtask
    // each enable alone, read back, and no temperature run from one bit
    task automatic t_fields;
        logic [31:0] d;
        for (int b = 5; b <= 14; b++) begin
            d = 32'h0008_0000 | (32'h0000_0001 << b);
            wr(32'h0000_2000, d);
            chk("enables", {22'h0, ens}, {22'h0, d[14:5]});
            chk("active", {31'h0, converter_active}, 32'h0000_0000);
            rd(32'h0000_2000);
            chk("readback", rd_q, d);
            chk("no temp run", {31'h0, temp_busy}, 32'h0000_0000);
        end
    endtask
    // all ones: reserved bits dropped, converter active
    task automatic t_reserved;
        wr(32'h0000_2000, 32'hFFFF_FFFF);
        chk("active", {31'h0, converter_active}, 32'h0000_0001);
        rd(32'h0000_2000);
        chk("masked", rd_q, 32'h0039_FFE0);
        wr(32'h0000_2000, 32'h0000_0000);
        rd(32'h0000_2008);
        chk("unmapped", rd_q, 32'h0000_0000);
    endtask
    // full conversion then an aborted one
    task automatic t_temp;
        wr(32'h0000_2000, 32'h0000_3000);
        wait_busy(1'b1);
        chk("busy", {31'h0, temp_busy}, 32'h0000_0001);
        wait_busy(1'b0);
        chk("busy end", {31'h0, temp_busy}, 32'h0000_0000);
        rd(32'h0000_2004);
        chk("result", rd_q, 32'h0000_A5C3);
        temp_sensor_pins <= 16'h1234;
        wr(32'h0000_2000, 32'h0000_3000);
        wait_busy(1'b1);
        wr(32'h0000_2000, 32'h0000_1000);
        repeat (2) @(posedge clk);
        #1 chk("abort", {31'h0, temp_busy}, 32'h0000_0000);
        rd(32'h0000_2004);
        chk("result kept", rd_q, 32'h0000_A5C3);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_fields();
        t_reserved();
        t_temp();
        stop_test();
    end
    // watchdog
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule
